// >>> rtl/rwsc_pkg.sv
// Purpose: Shared constants for the reset, wake and strap control block.
// Assumes: One 125 MHz system clock.
// Notes:   Counts are in cycles of clk_sys.
package rwsc_pkg;
  // ****************************************************************
  // Clock and strap decode
  // ****************************************************************
  localparam int unsigned REF_CLK_MHZ      = 25;
  localparam int unsigned SYS_CLK_MHZ      = 125;
  localparam int unsigned POR_TIME_NS      = 1000;
  localparam int unsigned POR_CYCLES       =
    (POR_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic        STRAP_RST_VAL    = 1'b1;
  localparam logic        SPEED_10         = 1'b0;
  localparam logic        SPEED_100        = 1'b1;
  localparam logic        DUPLEX_HALF      = 1'b0;
  localparam logic [1:0]  SYNC_RST_VAL     = 2'h0;

  typedef enum {
    RWSC_RUN,
    RWSC_SLEEP
  } rwsc_pwr_t;
endpackage : rwsc_pkg

// >>> rtl/rwsc_reset_sync.sv
// Purpose: Reset release synchroniser with a power-on hold counter.
// Assumes: Asynchronous active-low reset in, clk_sys running.
// Notes:   Assertion is immediate, release is aligned to clk_sys.
`timescale 1ns/10ps
module rwsc_reset_sync #(
  parameter int unsigned HOLD = rwsc_pkg::POR_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  output logic      rstSyncN
);
  logic [1:0]  syncQ;
  logic [15:0] holdQ;
  wire         holdDone = (holdQ == 16'(HOLD));

  // ****************************************************************
  // Two-stage release, then a short power-on hold
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      syncQ <= rwsc_pkg::SYNC_RST_VAL;
    end else begin
      syncQ <= {syncQ[0], 1'b1};
    end
  end

  // The hold keeps rstSyncN low until holdQ reaches HOLD; it only runs after resetn has been low.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      holdQ    <= 16'h0000;
      rstSyncN <= 1'b0;
    end else if (syncQ[1]) begin
      if (!holdDone) begin
        holdQ <= holdQ + 16'h0001;
      end
      rstSyncN <= holdDone;
    end
  end
endmodule : rwsc_reset_sync

// >>> rtl/rwsc_top.sv
// Purpose: Reset, wake indicator, write gating and speed strap control.
// Assumes: Host bus inputs are synchronous to clk_sys.
// Notes:   resetn models the external reset pin after its pull-up.
`timescale 1ns/10ps
module rwsc_top #(
  parameter int unsigned POR_HOLD = rwsc_pkg::POR_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic clkEn,
  input  wire logic chip_select_low,
  input  wire logic write_strobe_low,
  input  wire logic readStrobeN,
  input  wire logic speedStrap,
  input  wire logic sleepReq,
  input  wire logic wakeEvent,
  input  wire logic wakeEnable,
  input  wire logic wakeActiveHigh,
  input  wire logic wakeOpenDrain,
  output logic      wake_indicatorOut,
  output logic      wake_indicatorOe,
  output logic      writeAccept,
  output logic      inSleep,
  output logic      speed100,
  output logic      fullDuplex,
  output logic      autoNegEn,
  output logic      intRstN
);
  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstN;

  rwsc_reset_sync #(
    .HOLD     (POR_HOLD)
  ) uRst (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .rstSyncN (rstN)
  );

  // ****************************************************************
  // Host cycle decode
  // ****************************************************************
  // Both host cycles are a strobe qualified by the low chip select.
  function automatic logic qualifiedCycle(input logic selN,
                                          input logic strobeN);
    return !selN && !strobeN;
  endfunction : qualifiedCycle

  wire hostWrite = qualifiedCycle(chip_select_low, write_strobe_low);
  wire hostRead  = qualifiedCycle(chip_select_low, readStrobeN);

  rwsc_pkg::rwsc_pwr_t pwrQ;
  rwsc_pkg::rwsc_pwr_t pwrD;
  logic readSeenQ;
  logic strapQ;
  logic strapTakenQ;
  logic wakeAssertQ;

  // Only a write ends sleep; the wake event never does.
  always_comb begin
    pwrD = pwrQ;
    case (pwrQ)
      rwsc_pkg::RWSC_RUN: begin
        if (sleepReq) begin
          pwrD = rwsc_pkg::RWSC_SLEEP;
        end
      end
      rwsc_pkg::RWSC_SLEEP: begin
        if (hostWrite) begin
          pwrD = rwsc_pkg::RWSC_RUN;
        end
      end
      default: pwrD = rwsc_pkg::RWSC_RUN;
    endcase
  end

  wire sleepExit = (pwrQ == rwsc_pkg::RWSC_SLEEP) &&
                   (pwrD == rwsc_pkg::RWSC_RUN);
  // A read in the wake-up cycle itself still counts: the set wins.
  wire readSeenD = hostRead || (readSeenQ && !sleepExit);
  wire wakeOn    = wakeAssertQ;
  wire pinLevel  = wakeActiveHigh ? wakeOn : !wakeOn;

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pwrQ      <= rwsc_pkg::RWSC_RUN;
      readSeenQ <= 1'b0;
    end else if (clkEn) begin
      pwrQ      <= pwrD;
      readSeenQ <= readSeenD;
    end
  end

  // Strap taken on the first enabled edge after release, then frozen.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      strapQ      <= rwsc_pkg::STRAP_RST_VAL;
      strapTakenQ <= 1'b0;
    end else if (clkEn && !strapTakenQ) begin
      strapQ      <= speedStrap;
      strapTakenQ <= 1'b1;
    end
  end

  // Indicator holds until the device leaves sleep or is disabled.
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wakeAssertQ <= 1'b0;
    end else if (clkEn) begin
      if (!wakeEnable || sleepExit) begin
        wakeAssertQ <= 1'b0;
      end else if (wakeEvent && pwrQ == rwsc_pkg::RWSC_SLEEP) begin
        wakeAssertQ <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wake_indicatorOut <= 1'b0;
      wake_indicatorOe  <= 1'b0;
      writeAccept       <= 1'b0;
      inSleep           <= 1'b0;
      speed100          <= rwsc_pkg::SPEED_100;
      fullDuplex        <= rwsc_pkg::DUPLEX_HALF;
      autoNegEn         <= 1'b1;
      intRstN           <= 1'b0;
    end else if (clkEn) begin
      // Open drain only ever pulls low; high level comes from the pull-up.
      wake_indicatorOut <= wakeOpenDrain ? 1'b0 : pinLevel;
      wake_indicatorOe  <= wakeOpenDrain ? !pinLevel : 1'b1;
      writeAccept       <= hostWrite && readSeenQ &&
                           (pwrQ == rwsc_pkg::RWSC_RUN);
      inSleep           <= (pwrD == rwsc_pkg::RWSC_SLEEP);
      speed100          <= strapQ ? rwsc_pkg::SPEED_100
                                  : rwsc_pkg::SPEED_10;
      fullDuplex        <= rwsc_pkg::DUPLEX_HALF;
      autoNegEn         <= strapQ;
      intRstN           <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Every check sleeps through reset, so no one sees reset values in $past.
  a_write_needs_read: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && hostWrite && !readSeenQ |=> !writeAccept)
    else $error("write accepted before any read");

  a_sleep_write_exit: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && pwrQ == rwsc_pkg::RWSC_SLEEP && hostWrite
      |=> pwrQ == rwsc_pkg::RWSC_RUN)
    else $error("write did not end sleep");

  a_wake_no_exit: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && pwrQ == rwsc_pkg::RWSC_SLEEP && !hostWrite
      |=> pwrQ == rwsc_pkg::RWSC_SLEEP)
    else $error("sleep left without a write");

  a_wake_sets: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && wakeEnable && wakeEvent && pwrQ == rwsc_pkg::RWSC_SLEEP
      && !hostWrite |=> wakeAssertQ)
    else $error("wake event not flagged");

  a_strap_frozen: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    strapTakenQ |=> $stable(strapQ))
    else $error("strap changed after capture");

  a_strap_decode: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && strapTakenQ |=> speed100 == $past(strapQ)
      && autoNegEn == $past(strapQ) && !fullDuplex)
    else $error("default settings mismatch strap");

  a_pin_polarity: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && !wakeOpenDrain |=> wake_indicatorOe
      && wake_indicatorOut == $past(pinLevel))
    else $error("push-pull indicator level wrong");

  a_read_cleared: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && sleepExit && !hostRead |=> !readSeenQ)
    else $error("read flag kept across sleep exit");

  a_sleep_refuse: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && pwrQ == rwsc_pkg::RWSC_SLEEP |=> !writeAccept)
    else $error("write accepted while asleep");

  a_exit_clears_pin: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    clkEn && sleepExit |=> !wakeAssertQ)
    else $error("indicator kept after sleep exit");

  a_freeze_state: assert property (
    @(posedge clk_sys) disable iff (!rstN)
    !clkEn |=> $stable(pwrQ) && $stable(readSeenQ) && $stable(wakeAssertQ)
      && $stable(writeAccept))
    else $error("state moved while clock enable low");
endmodule : rwsc_top

// >>> tb/rwsc_host_model.sv
// Purpose: Host processor model driving the SRAM-like strobes.
// Assumes: Strobes change just after a rising clk_sys edge.
// Notes:   Address and data are not modelled.
`timescale 1ns/10ps
module rwsc_host_model (
  input  wire logic clk_sys,
  output logic      csN,
  output logic      wrN,
  output logic      rdN
);
  initial begin
    csN = 1'h1;
    wrN = 1'h1;
    rdN = 1'h1;
  end

  // A wake-up write is meant for the byte-order test register.
  task automatic access(input logic isWrite, input int n);
    @(posedge clk_sys);
    csN <= 1'h0;
    wrN <= !isWrite;
    rdN <= isWrite;
    repeat (n) @(posedge clk_sys);
    csN <= 1'h1;
    wrN <= 1'h1;
    rdN <= 1'h1;
  endtask : access
endmodule : rwsc_host_model

// >>> tb/tb_rwsc_top.sv
// Purpose: Self-checking bench for rwsc_top.
// Assumes: POR hold shortened to 2 cycles; clkEn dropped in one test.
// Notes:   The open-drain wake pin is seen through a pull-up.
`timescale 1ns/10ps
module tb_rwsc_top;
  logic clk_sys, resetn, strap, slpReq, wEv, wEn, wAh, wOd, rdSeen, slp;
  logic csN, wrN, rdN, wOut, wOe, wAcc, inSleep, spd, fdx, aneg, intRstN;
  logic ce;
  int   badCount, nCompared, acc, cyc;
  wire  pin = wOe ? wOut : 1'h1;

  rwsc_top #(.POR_HOLD(2)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .clkEn(ce), .chip_select_low(csN), .write_strobe_low(wrN),
    .readStrobeN(rdN), .speedStrap(strap), .sleepReq(slpReq),
    .wakeEvent(wEv), .wakeEnable(wEn), .wakeActiveHigh(wAh),
    .wakeOpenDrain(wOd), .wake_indicatorOut(wOut),
    .wake_indicatorOe(wOe), .writeAccept(wAcc), .inSleep(inSleep),
    .speed100(spd), .fullDuplex(fdx), .autoNegEn(aneg), .intRstN(intRstN));
  rwsc_host_model u_host (.clk_sys(clk_sys), .csN(csN), .wrN(wrN),
    .rdN(rdN));

  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Accepted writes are counted, not timed, so latency stays free.
  // The falling edge reads the registered pulse once it has settled.
  always @(negedge clk_sys) begin
    cyc++;
    if (wAcc === 1'h1) acc <= acc + 1;
    if (cyc == 20000) begin
      badCount++;
      testDone();
    end
  end

  task automatic chk(input logic got, input logic exp, input string what);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask : chk

  task automatic testDone();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : testDone

  task automatic rd();
    u_host.access(1'h0, 1);
    rdSeen = 1'h1;
    repeat (2) @(negedge clk_sys);
    chk(inSleep, slp, "read changed sleep");
  endtask : rd

  task automatic wr(input int n);
    int a0, e;
    a0 = acc;
    e = (rdSeen && !slp) ? n : 0;
    u_host.access(1'h1, n);
    if (slp) rdSeen = 1'h0;
    slp = 1'h0;
    repeat (3) @(negedge clk_sys);
    chk(acc - a0 == e, 1'h1, "write accept count");
    chk(inSleep, 1'h0, "sleep after write");
  endtask : wr

  // Enable low for the whole request: neither sleep nor a write may land.
  task automatic freeze_test();
    int a0;
    a0 = acc;
    @(posedge clk_sys);
    ce <= 1'h0;
    slpReq <= 1'h1;
    u_host.access(1'h1, 1 + $urandom % 2);
    @(posedge clk_sys);
    slpReq <= 1'h0;
    ce <= 1'h1;
    repeat (3) @(negedge clk_sys);
    chk(inSleep, 1'h0, "sleep taken while frozen");
    chk(acc == a0, 1'h1, "write taken while frozen");
    $display("test freeze end");
  endtask : freeze_test

  task automatic do_reset();
    @(posedge clk_sys);
    resetn <= 1'h0;
    strap <= 1'($urandom);
    repeat (2) @(negedge clk_sys);
    chk(intRstN, 1'h0, "internal reset");
    chk(spd & aneg & !inSleep & !wAcc, 1'h1, "reset values");
    @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (2) @(negedge clk_sys);
    chk(intRstN, 1'h0, "release not synchronised");
    repeat (10) @(negedge clk_sys);
    chk(intRstN, 1'h1, "internal release");
    chk(spd, strap, "strap speed");
    chk(aneg, strap, "strap autoneg");
    chk(fdx, 1'h0, "half duplex");
    @(posedge clk_sys);
    strap <= !strap;
    repeat (3) @(negedge clk_sys);
    chk(spd, !strap, "strap not held");
    rdSeen = 1'h0;
    slp = 1'h0;
    $display("test reset end");
  endtask : do_reset

  task automatic slp_test(input logic ah, input logic od, input logic en);
    @(posedge clk_sys);
    wAh <= ah;
    wOd <= od;
    wEn <= en;
    rd();
    @(posedge clk_sys);
    slpReq <= 1'h1;
    @(posedge clk_sys);
    slpReq <= 1'h0;
    slp = 1'h1;
    repeat (2) @(negedge clk_sys);
    chk(inSleep, 1'h1, "sleep entry");
    chk(pin, !ah, "idle wake pin");
    @(posedge clk_sys);
    wEv <= 1'h1;
    @(posedge clk_sys);
    wEv <= 1'h0;
    repeat (4) @(negedge clk_sys);
    chk(pin, en ? ah : !ah, "wake pin");
    chk(inSleep, 1'h1, "event left sleep");
    rd();
    wr(1 + $urandom % 2);
    repeat (2) @(negedge clk_sys);
    chk(pin, !ah, "wake pin not cleared");
    wr(1);
    rd();
    wr(2);
    $display("test sleep end");
  endtask : slp_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {resetn, slpReq, wEv, wAh, wOd, rdSeen, slp} = '0;
    {wEn, strap, ce} = 3'h7;
    void'($urandom(49759));
    repeat (2) @(posedge clk_sys);
    do_reset();
    wr(1);
    rd();
    wr(1 + $urandom % 3);
    freeze_test();
    for (int i = 0; i < 4; i++)
      slp_test(i[0], i[1], i != 2);
    do_reset();
    testDone();
  end
endmodule : tb_rwsc_top
